/* File: hdl/dspd_pkg.sv */
// Shared constants and types of the packed-SIMD op subfield decoder.
// Assumes a 32-bit instruction word with bit 31 as the most significant.
package dspd_pkg;

  // Major opcode and function field values
  localparam logic [5:0] DSPD_SPECIAL_THREE_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] DSPD_FUNC_ADDSUB = 6'h10;
  localparam logic [5:0] DSPD_FUNC_CMP = 6'h11;
  localparam logic [5:0] DSPD_FUNC_ABS = 6'h12;
  localparam logic [5:0] DSPD_FUNC_SHIFT_32 = 6'h13;
  localparam logic [5:0] DSPD_FUNC_ABS_64 = 6'h16;
  localparam logic [5:0] DSPD_FUNC_SHIFT_64 = 6'h17;

  // Op field values with a fixed meaning in the absolute sub-class
  localparam logic [4:0] DSPD_OP_SAT_ABS = 5'h09;
  localparam logic [4:0] DSPD_OP_REPL_IMM = 5'h0A;

  // Populated cells of the absolute sub-class tables, bit index = op
  localparam logic [31:0] DSPD_ABS_32_USED = 32'hF8023EFE;
  localparam logic [31:0] DSPD_ABS_64_USED = 32'hF03EFEFC;

  // Field positions in the instruction word
  localparam int DSPD_MAJOR_MSB = 31;
  localparam int DSPD_MAJOR_LSB = 26;
  localparam int DSPD_SRC_A_MSB = 25;
  localparam int DSPD_SRC_A_LSB = 21;
  localparam int DSPD_SRC_B_MSB = 20;
  localparam int DSPD_SRC_B_LSB = 16;
  localparam int DSPD_IMM_MSB = 25;
  localparam int DSPD_IMM_LSB = 16;
  localparam int DSPD_DEST_MSB = 15;
  localparam int DSPD_DEST_LSB = 11;
  localparam int DSPD_OP_MSB = 10;
  localparam int DSPD_OP_LSB = 6;
  localparam int DSPD_ROW_MSB = 10;
  localparam int DSPD_ROW_LSB = 9;
  localparam int DSPD_COL_MSB = 8;
  localparam int DSPD_COL_LSB = 6;
  localparam int DSPD_FUNC_MSB = 5;
  localparam int DSPD_FUNC_LSB = 0;

  // Decoded operation identifiers
  typedef enum logic [4:0] {
    OP_NONE,
    OP_EXT_OTHER,
    OP_ADDSUB_GROUP,
    OP_CMP_UNSIGNED_BYTE_EQUAL,
    OP_CMP_UNSIGNED_BYTE_LESS,
    OP_CMP_UNSIGNED_BYTE_LESS_EQUAL,
    OP_BYTE_PICK,
    OP_GPR_UNSIGNED_BYTE_EQUAL,
    OP_GPR_UNSIGNED_BYTE_LESS,
    OP_GPR_UNSIGNED_BYTE_LESS_EQUAL,
    OP_SIGNED_HALF_EQUAL,
    OP_SIGNED_HALF_LESS,
    OP_SIGNED_HALF_LESS_EQUAL,
    OP_HALFWORD_PICK,
    OP_HALF_TO_BYTE_REDUCE,
    OP_HALF_TO_BYTE_TRUNCATE,
    OP_PACK_RIGHT_LEFT_HALF,
    OP_SAT_UNSIGNED_REDUCE,
    OP_CMP_OTHER,
    OP_SAT_HALF_ABSOLUTE,
    OP_SAT_QUAD_HALF_ABSOLUTE,
    OP_HALF_REPLICATE_IMMEDIATE,
    OP_ABS_OTHER,
    OP_SHIFT_GROUP_32,
    OP_SHIFT_GROUP_64
  } dspd_op_t;

endpackage : dspd_pkg

/* File: hdl/dspd_cmp_table.sv */
// Op table of the compare / pick / precision-reduce sub-class.
// Assumes the caller has already selected that sub-class; pure logic.
`timescale 1ns/10ps
`default_nettype none

module dspd_cmp_table
  import dspd_pkg::*;
(
  input wire logic [1:0] i_row,
  input wire logic [2:0] i_col,
  output var dspd_op_t o_op,
  output logic o_reserved
);

  // Row picks element size, column picks the operation
  always_comb
  begin
    o_op = OP_CMP_OTHER;
    o_reserved = 1'b0;
    unique case (i_row)
      2'h0:
      begin
        unique case (i_col)
          3'h0: o_op = OP_CMP_UNSIGNED_BYTE_EQUAL;
          3'h1: o_op = OP_CMP_UNSIGNED_BYTE_LESS;
          3'h2: o_op = OP_CMP_UNSIGNED_BYTE_LESS_EQUAL;
          3'h3: o_op = OP_BYTE_PICK;
          3'h4: o_op = OP_GPR_UNSIGNED_BYTE_EQUAL;
          3'h5: o_op = OP_GPR_UNSIGNED_BYTE_LESS;
          3'h6: o_op = OP_GPR_UNSIGNED_BYTE_LESS_EQUAL;
          3'h7: o_reserved = 1'b1;
        endcase
      end
      2'h1:
      begin
        unique case (i_col)
          3'h0: o_op = OP_SIGNED_HALF_EQUAL;
          3'h1: o_op = OP_SIGNED_HALF_LESS;
          3'h2: o_op = OP_SIGNED_HALF_LESS_EQUAL;
          3'h3: o_op = OP_HALFWORD_PICK;
          3'h4: o_op = OP_HALF_TO_BYTE_REDUCE;
          3'h5: o_op = OP_HALF_TO_BYTE_TRUNCATE;
          3'h6: o_op = OP_PACK_RIGHT_LEFT_HALF;
          3'h7: o_op = OP_SAT_UNSIGNED_REDUCE;
        endcase
      end
      // Word-size rows: only a few cells are populated
      2'h2: o_reserved = (i_col != 3'h1) && (i_col != 3'h2);
      // Row 11 leaves its three middle columns empty
      2'h3: o_reserved = (i_col == 3'h3) || (i_col == 3'h4) ||
                         (i_col == 3'h5);
    endcase
    if (o_reserved)
    begin
      o_op = OP_NONE;
    end
  end

endmodule : dspd_cmp_table

`default_nettype wire

/* File: hdl/dspd_decoder.sv */
// Second-level decoder of the packed-SIMD extension: op field lookup,
// operand field extraction and reserved-code flagging.
// Assumes the fetch stage offers one word per cycle with a valid strobe
// on the same clock, and the execute stage takes the registered result.
`timescale 1ns/10ps
`default_nettype none

module dspd_decoder
  import dspd_pkg::*;
#(
  parameter bit P_RELEASE2 = 1'b1,
  parameter bit P_RESERVED_TRAPS = 1'b1
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  output logic o_valid,
  output var dspd_op_t o_op,
  output logic o_reserved,
  output logic o_ri_exc,
  output logic [4:0] o_source_reg_a,
  output logic [4:0] o_source_reg_b,
  output logic [4:0] o_dest_reg,
  output logic [4:0] o_shift_amount,
  output logic [9:0] o_imm10
);

  typedef struct packed {
    logic valid;
    dspd_op_t op;
    logic reserved;
    logic ri_exc;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [4:0] dest;
    logic [4:0] shamt;
    logic [9:0] imm;
  } dspd_state_t;

  dspd_state_t s_reg;
  dspd_state_t s_next;
  dspd_op_t cmp_op;
  logic cmp_reserved;
  logic [5:0] major;
  logic [5:0] func;
  logic [4:0] op_field;
  logic [1:0] row;
  logic [2:0] col;
  logic [4:0] src_a_field;
  logic [31:0] abs_used;

  // Raw fields of the offered word
  assign major = i_instr[DSPD_MAJOR_MSB:DSPD_MAJOR_LSB];
  assign func = i_instr[DSPD_FUNC_MSB:DSPD_FUNC_LSB];
  assign op_field = i_instr[DSPD_OP_MSB:DSPD_OP_LSB];
  assign row = i_instr[DSPD_ROW_MSB:DSPD_ROW_LSB];
  assign col = i_instr[DSPD_COL_MSB:DSPD_COL_LSB];
  assign src_a_field = i_instr[DSPD_SRC_A_MSB:DSPD_SRC_A_LSB];
  assign abs_used = (func == DSPD_FUNC_ABS) ? DSPD_ABS_32_USED
                                            : DSPD_ABS_64_USED;

  // Compare sub-class table lives apart to keep this body readable
  dspd_cmp_table u_cmp_table (
    .i_row(row),
    .i_col(col),
    .o_op(cmp_op),
    .o_reserved(cmp_reserved)
  );

  // Whole decode in one pass over the word
  always_comb
  begin
    s_next = '0;
    s_next.valid = i_valid;
    s_next.op = OP_NONE;
    s_next.src_a = src_a_field;
    s_next.src_b = i_instr[DSPD_SRC_B_MSB:DSPD_SRC_B_LSB];
    s_next.dest = i_instr[DSPD_DEST_MSB:DSPD_DEST_LSB];
    // Decode only when the major opcode matches
    if (i_valid && (major == DSPD_SPECIAL_THREE_MAJOR_OPCODE))
    begin
      if (!P_RELEASE2)
      begin
        // Older builds know none of this space
        s_next.reserved = 1'b1;
      end
      else
      begin
        unique case (func)
          DSPD_FUNC_ADDSUB: s_next.op = OP_ADDSUB_GROUP;
          DSPD_FUNC_CMP:
          begin
            s_next.op = cmp_op;
            s_next.reserved = cmp_reserved;
          end
          DSPD_FUNC_ABS, DSPD_FUNC_ABS_64:
          begin
            if (op_field == DSPD_OP_SAT_ABS)
            begin
              s_next.op = (func == DSPD_FUNC_ABS) ? OP_SAT_HALF_ABSOLUTE
                                                  : OP_SAT_QUAD_HALF_ABSOLUTE;
              // Nonzero upper field is a malformed word
              s_next.reserved = (src_a_field != 5'h00);
            end
            else if (op_field == DSPD_OP_REPL_IMM)
            begin
              s_next.op = OP_HALF_REPLICATE_IMMEDIATE;
              s_next.imm = i_instr[DSPD_IMM_MSB:DSPD_IMM_LSB];
            end
            else if (abs_used[op_field])
            begin
              s_next.op = OP_ABS_OTHER;
            end
            else
            begin
              s_next.reserved = 1'b1;
            end
          end
          DSPD_FUNC_SHIFT_32:
          begin
            s_next.op = OP_SHIFT_GROUP_32;
            s_next.shamt = src_a_field;
          end
          DSPD_FUNC_SHIFT_64:
          begin
            s_next.op = OP_SHIFT_GROUP_64;
            s_next.shamt = src_a_field;
          end
          // Other functions belong to sub-classes decoded elsewhere
          default: s_next.op = OP_EXT_OTHER;
        endcase
      end
      // Release-1 always traps; reserved codes trap only when chosen
      s_next.ri_exc = !P_RELEASE2 ||
                      (s_next.reserved && P_RESERVED_TRAPS);
    end
  end

  // Stage boundary register; the execute stage sees a clean snapshot
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign o_valid = s_reg.valid;
  assign o_op = s_reg.op;
  assign o_reserved = s_reg.reserved;
  assign o_ri_exc = s_reg.ri_exc;
  assign o_source_reg_a = s_reg.src_a;
  assign o_source_reg_b = s_reg.src_b;
  assign o_dest_reg = s_reg.dest;
  assign o_shift_amount = s_reg.shamt;
  assign o_imm10 = s_reg.imm;

  // Checks of the decode against the word one cycle earlier
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_ext_in(logic [5:0] f);
    i_valid && (major == DSPD_SPECIAL_THREE_MAJOR_OPCODE) && (func == f);
  endsequence

  sequence s_cmp_cell(logic [1:0] r, logic [2:0] c);
    s_ext_in(DSPD_FUNC_CMP) ##0 ((row == r) && (col == c));
  endsequence

  stage_valid_a: assert property (
    i_valid |=> o_valid)
    else $error("valid word not carried to decode stage");

  major_gate_a: assert property (
    (!i_valid || major != DSPD_SPECIAL_THREE_MAJOR_OPCODE)
      |=> (o_op == OP_NONE) && !o_ri_exc)
    else $error("operation decoded outside the major opcode");

  cmp_row0_a: assert property (
    P_RELEASE2 ##0 s_cmp_cell(2'h0, 3'h7) |=> o_reserved &&
      (o_op == OP_NONE) && (o_ri_exc == P_RESERVED_TRAPS))
    else $error("compare row 0 column 7 not reserved");

  cmp_row1_a: assert property (
    P_RELEASE2 ##0 s_cmp_cell(2'h1, 3'h0)
      |=> (o_op == OP_SIGNED_HALF_EQUAL) && !o_reserved)
    else $error("compare row 1 column 0 misdecoded");

  cmp_reduce_a: assert property (
    P_RELEASE2 ##0 s_cmp_cell(2'h1, 3'h7)
      |=> o_op == OP_SAT_UNSIGNED_REDUCE)
    else $error("saturating reduce misdecoded");

  abs_fields_a: assert property (
    P_RELEASE2 ##0 s_ext_in(DSPD_FUNC_ABS) ##0 (op_field == DSPD_OP_SAT_ABS)
      |=> (o_op == OP_SAT_HALF_ABSOLUTE) &&
          (o_reserved == (o_source_reg_a != 5'h00)) &&
          (o_source_reg_b == $past(i_instr[20:16])) &&
          (o_dest_reg == $past(i_instr[15:11])))
    else $error("absolute operands misdecoded");

  repl_imm_a: assert property (
    P_RELEASE2 ##0 s_ext_in(DSPD_FUNC_ABS) ##0 (op_field == DSPD_OP_REPL_IMM)
      |=> (o_op == OP_HALF_REPLICATE_IMMEDIATE) &&
          (o_imm10 == $past(i_instr[25:16])))
    else $error("replicate immediate misdecoded");

  shift_amt_a: assert property (
    P_RELEASE2 ##0 s_ext_in(DSPD_FUNC_SHIFT_64)
      |=> (o_op == OP_SHIFT_GROUP_64) &&
          (o_shift_amount == $past(i_instr[25:21])))
    else $error("shift group or amount misdecoded");

  old_release_a: assert property (
    !P_RELEASE2 && i_valid && (major == DSPD_SPECIAL_THREE_MAJOR_OPCODE)
      |=> o_ri_exc && o_reserved && (o_op == OP_NONE))
    else $error("release-1 build failed to trap");

  trap_select_a: assert property (
    o_ri_exc |-> !P_RELEASE2 || (o_reserved && P_RESERVED_TRAPS))
    else $error("trap raised without cause");

endmodule : dspd_decoder

`default_nettype wire

/* File: testbench/dspd_fetch_model.sv */
// Fetch-stage model: offers one instruction word a cycle to the decoder.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/10ps
`default_nettype none

module dspd_fetch_model
(
  input wire logic i_core_clk,
  output logic o_valid,
  output logic [31:0] o_instr
);
  logic [31:0] last_reg = 32'h0;

  // Idle at time zero with no word on offer
  initial
  begin
    o_valid = 1'b0;
    o_instr = 32'hFFFFFFFF;
  end

  // One word for one cycle, launched off the falling edge
  task automatic send(input logic [31:0] w);
    @(negedge i_core_clk);
    o_valid <= 1'b1;
    o_instr <= w;
    last_reg = w;
  endtask : send

  // Bubble: stale word lines flip so a stuck decode cannot pass
  task automatic idle();
    @(negedge i_core_clk);
    o_valid <= 1'b0;
    o_instr <= ~last_reg;
  endtask : idle
endmodule : dspd_fetch_model

`default_nettype wire

/* File: testbench/tb_dspd_decoder.sv */
// Self-checking bench of the op subfield decoder.
// Assumes default parameters: release-2 build, reserved codes trap.
`timescale 1ns/10ps
`default_nettype none

module tb_dspd_decoder
  import dspd_pkg::*;
;
  typedef struct packed {
    dspd_op_t op;
    logic resv;
    logic exc;
    logic r1;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [4:0] dest;
    logic [4:0] shamt;
    logic [9:0] imm;
  } dspd_exp_t;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic fetch_valid;
  wire logic [31:0] fetch_instr;
  logic o_valid, o_reserved, o_ri_exc;
  dspd_op_t o_op;
  logic [4:0] o_source_reg_a, o_source_reg_b, o_dest_reg, o_shift_amount;
  logic [9:0] o_imm10;
  logic r1_valid, r1_reserved, r1_ri_exc, nt_reserved, nt_ri_exc;
  dspd_op_t r1_op, nt_op;
  int fail_count = 0;
  int comparisons = 0;
  dspd_exp_t exp_q[$];
  dspd_exp_t mon_e;
  // Compare op table indexed by the whole op field; OP_NONE marks reserved
  dspd_op_t cmp_tab [32] = '{OP_CMP_UNSIGNED_BYTE_EQUAL,
    OP_CMP_UNSIGNED_BYTE_LESS, OP_CMP_UNSIGNED_BYTE_LESS_EQUAL,
    OP_BYTE_PICK, OP_GPR_UNSIGNED_BYTE_EQUAL, OP_GPR_UNSIGNED_BYTE_LESS,
    OP_GPR_UNSIGNED_BYTE_LESS_EQUAL, OP_NONE, OP_SIGNED_HALF_EQUAL,
    OP_SIGNED_HALF_LESS, OP_SIGNED_HALF_LESS_EQUAL, OP_HALFWORD_PICK,
    OP_HALF_TO_BYTE_REDUCE, OP_HALF_TO_BYTE_TRUNCATE,
    OP_PACK_RIGHT_LEFT_HALF, OP_SAT_UNSIGNED_REDUCE,
    OP_NONE, OP_CMP_OTHER, OP_CMP_OTHER, OP_NONE, OP_NONE, OP_NONE,
    OP_NONE, OP_NONE, OP_CMP_OTHER, OP_CMP_OTHER, OP_CMP_OTHER, OP_NONE,
    OP_NONE, OP_NONE, OP_CMP_OTHER, OP_CMP_OTHER};

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  dspd_fetch_model i_fetch (.i_core_clk(core_clk), .o_valid(fetch_valid),
    .o_instr(fetch_instr));

  dspd_decoder i_dut (.i_core_clk(core_clk), .i_rst_n(rst_n),
    .i_valid(fetch_valid), .i_instr(fetch_instr), .o_valid(o_valid),
    .o_op(o_op), .o_reserved(o_reserved), .o_ri_exc(o_ri_exc),
    .o_source_reg_a(o_source_reg_a), .o_source_reg_b(o_source_reg_b),
    .o_dest_reg(o_dest_reg), .o_shift_amount(o_shift_amount),
    .o_imm10(o_imm10));

  // Release-1 build: every special-three word must trap, whatever the choice
  dspd_decoder #(.P_RELEASE2(1'b0), .P_RESERVED_TRAPS(1'b0)) i_dut_r1 (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_valid(fetch_valid),
    .i_instr(fetch_instr), .o_valid(r1_valid), .o_op(r1_op),
    .o_reserved(r1_reserved), .o_ri_exc(r1_ri_exc), .o_source_reg_a(),
    .o_source_reg_b(), .o_dest_reg(), .o_shift_amount(), .o_imm10());

  // Release-2 build that flags reserved codes but never traps them
  dspd_decoder #(.P_RELEASE2(1'b1), .P_RESERVED_TRAPS(1'b0)) i_dut_nt (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_valid(fetch_valid),
    .i_instr(fetch_instr), .o_valid(), .o_op(nt_op),
    .o_reserved(nt_reserved), .o_ri_exc(nt_ri_exc), .o_source_reg_a(),
    .o_source_reg_b(), .o_dest_reg(), .o_shift_amount(), .o_imm10());

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Reference decode, limited to the cells this bench offers
  function automatic dspd_exp_t expect_of(input logic [31:0] w);
    dspd_exp_t e;
    e = '0;
    e.op = OP_NONE;
    {e.src_a, e.src_b, e.dest} = w[25:11];
    if (w[31:26] == 6'h1F)
    begin
      // Functions left to other decoders are passed on, never reserved
      e.op = OP_EXT_OTHER;
      if (w[5:0] == 6'h11)
      begin
        e.op = cmp_tab[w[10:6]];
        e.resv = (e.op == OP_NONE);
      end
      else if (w[5:0] == 6'h12 || w[5:0] == 6'h16)
      begin
        if (w[10:6] == 5'h0A)
        begin
          e.op = OP_HALF_REPLICATE_IMMEDIATE;
          e.imm = w[25:16];
        end
        else
        begin
          // Only op 01001 is offered; a nonzero upper field is malformed
          e.op = w[2] ? OP_SAT_QUAD_HALF_ABSOLUTE : OP_SAT_HALF_ABSOLUTE;
          e.resv = (w[25:21] != 5'h00);
        end
      end
      else if (w[5:0] == 6'h13 || w[5:0] == 6'h17)
      begin
        e.op = w[2] ? OP_SHIFT_GROUP_64 : OP_SHIFT_GROUP_32;
        e.shamt = w[25:21];
      end
      else if (w[5:0] == 6'h10)
        e.op = OP_ADDSUB_GROUP;
      e.exc = e.resv;
      e.r1 = 1'b1;
    end
    return e;
  endfunction : expect_of

  function automatic logic [31:0] mk(input logic [5:0] f,
    input logic [4:0] op, input logic [14:0] regs);
    return {6'h1F, regs, op, f};
  endfunction : mk

  // Offer a word and note what must come out one cycle later
  task automatic issue(input logic [31:0] w);
    i_fetch.send(w);
    exp_q.push_back(expect_of(w));
  endtask : issue

  // Output watcher: every valid result consumes the oldest note
  always @(negedge core_clk)
  begin
    if (rst_n === 1'b1 && o_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("o_valid", 32'(o_valid), 32'h0);
      else
      begin
        mon_e = exp_q.pop_front();
        check("o_op", 32'(o_op), 32'(mon_e.op));
        check("o_reserved", 32'(o_reserved), 32'(mon_e.resv));
        check("o_ri_exc", 32'(o_ri_exc), 32'(mon_e.exc));
        check("o_source_reg_a", 32'(o_source_reg_a), 32'(mon_e.src_a));
        check("o_source_reg_b", 32'(o_source_reg_b), 32'(mon_e.src_b));
        check("o_dest_reg", 32'(o_dest_reg), 32'(mon_e.dest));
        check("o_shift_amount", 32'(o_shift_amount), 32'(mon_e.shamt));
        check("o_imm10", 32'(o_imm10), 32'(mon_e.imm));
        check("r1_valid", 32'(r1_valid), 32'h1);
        check("r1_op", 32'(r1_op), 32'(OP_NONE));
        check("r1_reserved", 32'(r1_reserved), 32'(mon_e.r1));
        check("r1_ri_exc", 32'(r1_ri_exc), 32'(mon_e.r1));
        check("nt_op", 32'(nt_op), 32'(mon_e.op));
        check("nt_reserved", 32'(nt_reserved), 32'(mon_e.resv));
        check("nt_ri_exc", 32'(nt_ri_exc), 32'h0);
      end
    end
  end

  // Main sequence: back-to-back words, then a bubble and a foreign word
  initial
  begin
    logic [31:0] w;
    int n;
    w = $urandom(90);
    repeat (12) @(negedge core_clk);
    check("o_valid", 32'(o_valid), 32'h0);
    check("o_op", 32'(o_op), 32'(OP_NONE));
    rst_n = 1'b1;
    for (n = 0; n < 32; n++)
      issue(mk(6'h11, 5'(n), 15'($urandom)));
    for (n = 0; n < 2; n++)
    begin
      w[5:0] = (n == 0) ? 6'h12 : 6'h16;
      issue(mk(w[5:0], 5'h09, {5'h00, 10'($urandom)}));
      issue(mk(w[5:0], 5'h09, {5'h01, 10'($urandom)}));
      issue(mk(w[5:0], 5'h0A, 15'($urandom)));
    end
    issue(mk(6'h13, 5'($urandom), 15'($urandom)));
    issue(mk(6'h17, 5'($urandom), 15'($urandom)));
    issue(mk(6'h10, 5'($urandom), 15'($urandom)));
    i_fetch.idle();
    w = $urandom;
    w[31:26] = (w[31:26] == 6'h1F) ? 6'h1E : w[31:26];
    issue(w);
    i_fetch.idle();
    for (n = 0; n < 10 && exp_q.size() != 0; n++)
      @(negedge core_clk);
    check("pending results", 32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule : tb_dspd_decoder

`default_nettype wire
